//--- bsag_cfg.svh
// Constants for the bus strobe and address generator: register offsets,
// field positions, reset values and strap timing counts.
// Assumes inclusion by bare name from bsag_top; the package and the memory model do not include it.
`ifndef BSAG_CFG_SVH
`define BSAG_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define BSAG_REG_TOP_REGION  8'h00
`define BSAG_REG_CTRL        8'h04
`define BSAG_REG_STATUS      8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define BSAG_TOP_BASE_LSB    0
`define BSAG_TOP_BASE_MSB    3
`define BSAG_TOP_SIZE_LSB    4
`define BSAG_TOP_SIZE_MSB    5
`define BSAG_CTRL_BUS8_BIT   0
`define BSAG_ST_FLOAT_BIT    0
`define BSAG_ST_CLK_LSB      1
`define BSAG_ST_CLK_MSB      2
`define BSAG_ST_HOLD_BIT     3
`define BSAG_ST_DONE_BIT     4
`define BSAG_ST_STATE_LSB    5
`define BSAG_ST_STATE_MSB    7

// ****************************************************************
// Reset values
// ****************************************************************
`define BSAG_TOP_BASE_RST    4'hF
`define BSAG_TOP_SIZE_RST    2'h0
`define BSAG_BUS8_RST        1'h0
`define BSAG_STRAP_SYNC_RST  4'hF
`define BSAG_BOOT_FETCH_ADDR 20'hFFFF0

// ****************************************************************
// Strap timing, in clock cycles after reset release
// ****************************************************************
`define BSAG_STRAP_TAKE_CYC  2'h2
`define BSAG_STRAP_LIMIT_CYC 3

`endif

//--- bsag_pkg.sv
// Types shared by the bus strobe and address generator modules.
// Assumes no include path; it does not include bsag_cfg.svh.
`default_nettype none

package bsag_pkg;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1   = 3'h1,
        ST_T2   = 3'h3,
        ST_T3   = 3'h2,
        ST_T4   = 3'h6
    } bsag_state_e;

    // Encoded as {pll_strap2, pll_strap1}
    typedef enum logic [1:0] {
        CLK_RSVD = 2'h0,
        CLK_X1   = 2'h1,
        CLK_DIV2 = 2'h2,
        CLK_X4   = 2'h3
    } bsag_clk_mode_e;

    typedef enum logic [1:0] {
        REF_FETCH  = 2'h0,
        REF_DATA   = 2'h1,
        REF_STACK  = 2'h2,
        REF_STRING = 2'h3
    } bsag_ref_e;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [15:0] code_seg;
        logic [15:0] data_seg;
        logic [15:0] stack_seg;
        logic [15:0] extra_seg;
    } bsag_segs_s;

    typedef struct packed {
        logic        is_io;
        logic        is_write;
        bsag_ref_e   kind;
        logic        via_base_ptr;
        logic        via_dest_index;
        logic        port_imm;
        logic [7:0]  port_imm8;
        logic [15:0] port_index_reg;
        logic [15:0] offset;
        logic        upper_lane_sel_n;
    } bsag_req_s;

    typedef struct packed {
        logic [19:0] addr;
        logic        top_region_sel_n;
        logic        vector_area_hint;
        logic        hi_lane_store_n;
        logic        lo_lane_store_n;
        logic        byte_store_n;
        logic        store_strobe_n;
    } bsag_pins_s;

    typedef struct packed {
        logic addr;
        logic top_region_sel;
        logic vector_area_hint;
        logic lane_stores;
        logic store_strobe;
    } bsag_oe_s;

endpackage : bsag_pkg

`default_nettype wire

//--- bsag_sync.sv
// Two-stage synchroniser for pin levels entering the clock domain.
// Assumes levels only; pulses shorter than one clock may be missed.
`timescale 1ns/1ns
`default_nettype none

module bsag_sync #(
    parameter int unsigned        WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    input  wire logic             i_clk_en,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else if (i_clk_en) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : bsag_sync

`default_nettype wire

//--- bsag_top.sv
// Bus strobe and address generator: physical and I/O address forming,
// top-region select, vector-area hint, byte store enables, store strobe,
// reset strap capture. Register port: address, data, write/read strobes.
// Assumes the core offers a cycle only while o_cyc_ready is high.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "bsag_cfg.svh"

module bsag_top (
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_clk_en,
    // Reset straps and bus hold (pins)
    input  wire logic                    i_pin_float_req0_n,
    input  wire logic                    i_pin_float_req1_n,
    input  wire logic                    i_pll_strap1,
    input  wire logic                    i_pll_strap2,
    input  wire logic                    i_hold,
    // Core cycle request
    input  wire logic                    i_cyc_req,
    input  wire bsag_pkg::bsag_req_s     i_req,
    input  wire bsag_pkg::bsag_segs_s    i_segs,
    output logic                         o_cyc_ready,
    // Register port
    input  wire logic [7:0]              i_reg_addr,
    input  wire logic [15:0]             i_reg_wdata,
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    output logic      [15:0]             o_reg_rdata,
    // Pins
    output bsag_pkg::bsag_pins_s         o_pins,
    output bsag_pkg::bsag_oe_s           o_pins_oe,
    // Strap results
    output logic                         o_float_test_mode,
    output bsag_pkg::bsag_clk_mode_e     o_clk_mode
);
    import bsag_pkg::*;

    localparam int STRAP_LIMIT = `BSAG_STRAP_LIMIT_CYC;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] strap_s;
    logic       hold_s;

    bsag_sync #(.WIDTH(4), .RST_VAL(`BSAG_STRAP_SYNC_RST)) u_strap_sync (
        .i_clock  (i_clock),
        .i_rst_b  (i_rst_b),
        .i_clk_en (i_clk_en),
        .i_async  ({i_pin_float_req1_n, i_pin_float_req0_n,
                    i_pll_strap2, i_pll_strap1}),
        .o_sync   (strap_s)
    );

    bsag_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_hold_sync (
        .i_clock  (i_clock),
        .i_rst_b  (i_rst_b),
        .i_clk_en (i_clk_en),
        .i_async  (i_hold),
        .o_sync   (hold_s)
    );

    // ****************************************************************
    // Strap capture after reset release
    // ****************************************************************
    logic [1:0]     strap_cnt_r;
    logic           strap_done_r;
    logic           float_r;
    bsag_clk_mode_e clk_mode_r;

    // Pins settle through the synchroniser before the take cycle
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'h0;
            float_r      <= 1'h0;
            clk_mode_r   <= CLK_X4;
        end else if (i_clk_en && !strap_done_r) begin
            if (strap_cnt_r == `BSAG_STRAP_TAKE_CYC) begin
                strap_done_r <= 1'h1;
                float_r      <= (strap_s[3:2] == 2'h0);
                clk_mode_r   <= bsag_clk_mode_e'(strap_s[1:0]);
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    assign o_float_test_mode = float_r;
    assign o_clk_mode        = clk_mode_r;

    // ****************************************************************
    // Register port
    // ****************************************************************
    logic [3:0]  top_base_r;
    logic [1:0]  top_size_r;
    logic        bus8_r;
    logic [15:0] rdata_r;
    bsag_state_e state_r;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            top_base_r <= `BSAG_TOP_BASE_RST;
            top_size_r <= `BSAG_TOP_SIZE_RST;
            bus8_r     <= `BSAG_BUS8_RST;
        end else if (i_clk_en && i_reg_wr) begin
            if (i_reg_addr == `BSAG_REG_TOP_REGION) begin
                // Two-bit size code caps the window at 512 Kbyte
                top_base_r <= i_reg_wdata[`BSAG_TOP_BASE_MSB:
                                          `BSAG_TOP_BASE_LSB];
                top_size_r <= i_reg_wdata[`BSAG_TOP_SIZE_MSB:
                                          `BSAG_TOP_SIZE_LSB];
            end
            if (i_reg_addr == `BSAG_REG_CTRL) begin
                bus8_r <= i_reg_wdata[`BSAG_CTRL_BUS8_BIT];
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= 16'h0000;
        end else if (i_clk_en) begin
            rdata_r <= 16'h0000;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    `BSAG_REG_TOP_REGION: begin
                        rdata_r[`BSAG_TOP_BASE_MSB:`BSAG_TOP_BASE_LSB]
                            <= top_base_r;
                        rdata_r[`BSAG_TOP_SIZE_MSB:`BSAG_TOP_SIZE_LSB]
                            <= top_size_r;
                    end
                    `BSAG_REG_CTRL: begin
                        rdata_r[`BSAG_CTRL_BUS8_BIT] <= bus8_r;
                    end
                    `BSAG_REG_STATUS: begin
                        rdata_r[`BSAG_ST_FLOAT_BIT] <= float_r;
                        rdata_r[`BSAG_ST_CLK_MSB:`BSAG_ST_CLK_LSB]
                            <= clk_mode_r;
                        rdata_r[`BSAG_ST_HOLD_BIT]  <= hold_s;
                        rdata_r[`BSAG_ST_DONE_BIT]  <= strap_done_r;
                        rdata_r[`BSAG_ST_STATE_MSB:`BSAG_ST_STATE_LSB]
                            <= state_r;
                    end
                    default: begin
                        rdata_r <= 16'h0000;
                    end
                endcase
            end
        end
    end

    assign o_reg_rdata = rdata_r;

    // ****************************************************************
    // Address forming
    // ****************************************************************
    logic [15:0] seg_sel;
    logic [19:0] addr_nxt;
    logic        acc;

    always_comb begin
        if (i_req.kind == REF_STRING && i_req.via_dest_index) begin
            seg_sel = i_segs.extra_seg;
        end else if (i_req.kind == REF_STACK || i_req.via_base_ptr) begin
            seg_sel = i_segs.stack_seg;
        end else if (i_req.kind == REF_FETCH) begin
            seg_sel = i_segs.code_seg;
        end else begin
            seg_sel = i_segs.data_seg;
        end
        if (i_req.is_io) begin
            addr_nxt = i_req.port_imm ? {12'h000, i_req.port_imm8}
                                      : {4'h0, i_req.port_index_reg};
        end else begin
            // Carry past bit 19 wraps within the megabyte
            addr_nxt = {seg_sel, 4'h0} + {4'h0, i_req.offset};
        end
    end

    function automatic logic region_hit(input logic [19:0] a,
                                        input logic [3:0]  base,
                                        input logic [1:0]  size);
        logic [3:0] mask;
        mask = 4'hF << size;
        return (a[19:16] & mask) == (base & mask);
    endfunction : region_hit

    // ****************************************************************
    // Bus cycle sequencer
    // ****************************************************************
    bsag_state_e state_nxt;
    logic        cyc_write_r;
    logic        cyc_io_r;
    logic        cyc_upper_n_r;

    assign o_cyc_ready = (state_r == ST_IDLE) && !hold_s && !float_r
                         && strap_done_r;
    assign acc = i_cyc_req && o_cyc_ready;

    always_comb begin
        unique case (state_r)
            ST_IDLE: state_nxt = acc ? ST_T1 : ST_IDLE;
            ST_T1:   state_nxt = ST_T2;
            ST_T2:   state_nxt = ST_T3;
            ST_T3:   state_nxt = ST_T4;
            ST_T4:   state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
        end else if (i_clk_en) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc_write_r   <= 1'h0;
            cyc_io_r      <= 1'h0;
            cyc_upper_n_r <= 1'h1;
        end else if (i_clk_en && acc) begin
            cyc_write_r   <= i_req.is_write;
            cyc_io_r      <= i_req.is_io;
            cyc_upper_n_r <= i_req.upper_lane_sel_n;
        end
    end

    // ****************************************************************
    // Pin values
    // ****************************************************************
    bsag_pins_s pins_r;
    bsag_oe_s   oe_r;
    logic       strobe_nxt;
    logic       in_store;

    assign in_store   = (state_nxt == ST_T2) || (state_nxt == ST_T3);
    assign strobe_nxt = !(cyc_write_r && in_store);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pins_r <= '{addr: 20'h00000, default: 1'h1};
            pins_r.vector_area_hint <= 1'h0;
        end else if (i_clk_en) begin
            if (acc) begin
                pins_r.addr <= addr_nxt;
            end
            // Only the first period carries the hint
            pins_r.vector_area_hint <= acc && !(|addr_nxt[19:16]);
            if (acc) begin
                pins_r.top_region_sel_n <= hold_s || i_req.is_io
                    || !region_hit(addr_nxt, top_base_r, top_size_r);
            end else if (state_nxt == ST_IDLE || hold_s) begin
                pins_r.top_region_sel_n <= 1'h1;
            end
            pins_r.store_strobe_n  <= strobe_nxt;
            pins_r.hi_lane_store_n <= cyc_upper_n_r | strobe_nxt;
            pins_r.lo_lane_store_n <= pins_r.addr[0] | strobe_nxt;
            // Eight-bit variant drives early, alongside the address
            if (acc) begin
                pins_r.byte_store_n <= !(bus8_r && i_req.is_write);
            end else begin
                pins_r.byte_store_n <= !(bus8_r && cyc_write_r
                                         && in_store);
            end
        end
    end

    // Float mode never clears short of reset
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_r <= '0;
        end else if (i_clk_en) begin
            oe_r.addr             <= !hold_s && !float_r;
            oe_r.top_region_sel   <= !float_r;
            oe_r.vector_area_hint <= !hold_s && !float_r;
            oe_r.lane_stores      <= !hold_s && !float_r;
            oe_r.store_strobe     <= !hold_s && !float_r;
        end
    end

    assign o_pins    = pins_r;
    assign o_pins_oe = oe_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [19:0] chk_stack_addr;
    logic [19:0] chk_extra_addr;

    assign chk_stack_addr = {i_segs.stack_seg, 4'h0} + {4'h0, i_req.offset};
    assign chk_extra_addr = {i_segs.extra_seg, 4'h0} + {4'h0, i_req.offset};

    sequence s_hint_t1;
        o_pins.vector_area_hint == !(|o_pins.addr[19:16]);
    endsequence

    sequence s_hint_gone;
        !o_pins.vector_area_hint;
    endsequence

    a_hint_first_period: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        acc |=> s_hint_t1 ##1 s_hint_gone)
        else $error("vector hint not confined to first period");

    a_hi_lane_write: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && i_req.is_write && !i_req.upper_lane_sel_n && !hold_s)
        |=> o_pins.hi_lane_store_n ##1 !o_pins.hi_lane_store_n [*2]
            ##1 o_pins.hi_lane_store_n)
        else $error("high lane store enable timing wrong");

    a_lo_lane_odd: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && i_req.is_write && addr_nxt[0])
        |=> o_pins.lo_lane_store_n [*4])
        else $error("low lane enabled for odd address");

    a_byte_store_early: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && i_req.is_write && bus8_r)
        |=> !o_pins.byte_store_n [*3] ##1 o_pins.byte_store_n)
        else $error("byte store enable not early or not released");

    a_top_hold_high: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        hold_s |=> o_pins.top_region_sel_n)
        else $error("top region select low during hold");

    a_boot_fetch_sel: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && !i_req.is_io && !hold_s
         && addr_nxt == `BSAG_BOOT_FETCH_ADDR
         && top_base_r == `BSAG_TOP_BASE_RST
         && top_size_r == `BSAG_TOP_SIZE_RST)
        |=> !o_pins.top_region_sel_n)
        else $error("default window misses boot fetch");

    a_strobe_hold_off: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        hold_s |=> !o_pins_oe.store_strobe && !o_pins_oe.vector_area_hint)
        else $error("strobe or hint driven during hold");

    a_float_all_off: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        float_r |=> float_r && o_pins_oe == '0 && !o_cyc_ready)
        else $error("pin driven in float test mode");

    a_float_sampled: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        $rose(strap_done_r) |-> (float_r == ($past(strap_s[3:2]) == 2'h0)))
        else $error("float request straps not applied");

    a_clk_mode_taken: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        $rose(strap_done_r) |-> o_clk_mode == $past(strap_s[1:0]))
        else $error("clock mode does not match straps");

    a_strap_window: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        strap_done_r || (strap_cnt_r < STRAP_LIMIT))
        else $error("straps not captured within window");

    a_io_zero_ext: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && i_req.is_io && i_req.port_imm)
        |=> o_pins.addr[19:8] == 12'h000)
        else $error("short port number not zero extended");

    a_stack_addr: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && !i_req.is_io && i_req.kind == REF_DATA && i_req.via_base_ptr)
        |=> o_pins.addr == $past(chk_stack_addr))
        else $error("base pointer reference not on stack segment");

    a_extra_addr: assert property (
        @(posedge i_clock) disable iff (!i_rst_b || !i_clk_en)
        (acc && !i_req.is_io && i_req.kind == REF_STRING
         && i_req.via_dest_index)
        |=> o_pins.addr == $past(chk_extra_addr))
        else $error("string destination not on extra segment");

endmodule : bsag_top

`default_nettype wire

//--- bsag_mem_model.sv
// External memory at the pins: keeps the address of the last write.
// Assumes pins change only just after the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module bsag_mem_model (
    // Clock
    input  wire logic                 i_clock,
    // Pins from the device
    input  wire bsag_pkg::bsag_pins_s i_pins,
    input  wire bsag_pkg::bsag_oe_s   i_oe,
    // Captured write address
    output logic [19:0]               o_wr_addr
);
    import bsag_pkg::*;
    // ****************************************************************
    // Write capture
    // ****************************************************************
    // A floating strobe writes nothing, whatever level it seems to show
    always_ff @(posedge i_clock) begin
        if (i_oe.store_strobe && !i_pins.store_strobe_n) begin
            o_wr_addr <= i_pins.addr;
        end
    end
endmodule : bsag_mem_model
`default_nettype wire

//--- tb.sv
// Testbench for bsag_top: straps, bus cycles, register port, hold.
// Assumes bsag_pkg, bsag_top and bsag_mem_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bsag_pkg::*;
    // ****************************************************************
    // Signals, design and memory
    // ****************************************************************
    logic        clk, rst_b, hold, req, wr, rd, rdy, fl, cen;
    logic [3:0]  strap;
    logic [7:0]  ra;
    logic [15:0] wd, rdat;
    logic [19:0] wa;
    bsag_req_s   rq;
    bsag_segs_s  sg;
    bsag_pins_s  p;
    bsag_oe_s    oe;
    bsag_clk_mode_e cm;
    int          fail_count, check_count;
    bsag_top DUT (.i_clock(clk), .i_rst_b(rst_b), .i_clk_en(cen),
        .i_pin_float_req0_n(strap[3]), .i_pin_float_req1_n(strap[2]),
        .i_pll_strap1(strap[1]), .i_pll_strap2(strap[0]), .i_hold(hold),
        .i_cyc_req(req), .i_req(rq), .i_segs(sg), .o_cyc_ready(rdy),
        .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdat), .o_pins(p), .o_pins_oe(oe),
        .o_float_test_mode(fl), .o_clk_mode(cm));
    bsag_mem_model MEM (.i_clock(clk), .i_pins(p), .i_oe(oe),
        .o_wr_addr(wa));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic rst(input logic [3:0] v);
        @(posedge clk);
        strap <= v;
        rst_b <= 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask : rst
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({4'h0, rdat}, {4'h0, e});
    endtask : rreg
    function automatic bsag_req_s mk(bsag_ref_e k, logic [5:0] f,
                                     logic [15:0] o);
        mk = '0;
        {mk.is_io, mk.is_write, mk.via_base_ptr, mk.via_dest_index,
         mk.port_imm, mk.upper_lane_sel_n} = f;
        mk.kind = k;
        mk.port_imm8 = 8'hAB;
        mk.port_index_reg = 16'hBEEF;
        mk.offset = o;
    endfunction : mk
    // Expected {top_n, hint, byte_n} at T1 is given by the caller
    task automatic cyc(input bsag_req_s r, input logic [19:0] a,
                       input logic [2:0] e);
        int n;
        logic w;
        w = r.is_write;
        for (n = 0; n < 40 && rdy !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 40) fail_count++;
        @(posedge clk);
        rq <= r;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        #1;
        chk(p.addr, a);
        chk({17'h0, p.top_region_sel_n, p.vector_area_hint,
             p.byte_store_n}, {17'h0, e});
        @(posedge clk);
        #1;
        chk({16'h0, p.vector_area_hint, p.store_strobe_n,
             p.hi_lane_store_n, p.lo_lane_store_n},
            {16'h0, 1'b0, ~w, ~w | r.upper_lane_sel_n,
             ~w | a[0]});
        @(posedge clk);
        #1;
        if (w) chk(wa, a);
    endtask : cyc
    task automatic t_cycles();
        cyc(mk(REF_FETCH, 6'h00, 16'h0000), 20'hFFFF0, 3'b001);
        cyc(mk(REF_DATA, 6'h18, 16'h0011), 20'h20011, 3'b101);
        cyc(mk(REF_STRING, 6'h14, 16'h0010), 20'h00010, 3'b111);
        cyc(mk(REF_DATA, 6'h00, 16'h0005), 20'h12345, 3'b101);
        cyc(mk(REF_DATA, 6'h22, 16'h0000), 20'h000AB, 3'b111);
        cyc(mk(REF_DATA, 6'h20, 16'h0000), 20'h0BEEF, 3'b111);
    endtask : t_cycles
    task automatic t_region();
        wreg(8'h00, 16'h0018);
        rreg(8'h00, 16'h0018);
        rreg(8'h0C, 16'h0000);
        @(posedge clk);
        sg.data_seg <= 16'h7000;
        cyc(mk(REF_DATA, 6'h00, 16'hFFF0), 20'h7FFF0, 3'b101);
        @(posedge clk);
        sg.data_seg <= 16'h8000;
        wreg(8'h04, 16'h0001);
        cyc(mk(REF_DATA, 6'h11, 16'h0000), 20'h80000, 3'b000);
    endtask : t_region
    task automatic t_hold();
        @(posedge clk);
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({13'h0, oe, p.top_region_sel_n, rdy}, 20'h00022);
        @(posedge clk);
        hold <= 1'b0;
    endtask : t_hold
    // Frozen clock enable must keep a hold from reaching the pins
    task automatic t_freeze();
        @(posedge clk);
        cen  <= 1'b0;
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({14'h0, oe, rdy}, 20'h0003F);
        @(posedge clk);
        cen  <= 1'b1;
        hold <= 1'b0;
    endtask : t_freeze
    task automatic t_straps();
        rst(4'b1110);
        chk({17'h0, fl, cm}, {17'h0, 1'b0, CLK_X1});
        rst(4'b0001);
        chk({12'h0, fl, cm, oe},
            {12'h0, 1'b1, CLK_DIV2, 5'h00});
    endtask : t_straps
    initial begin
        {rst_b, hold, req, wr, rd, strap, ra, wd} = '0;
        rq = '0;
        cen = 1'b1;
        sg = {16'hFFFF, 16'h1234, 16'h2000, 16'h0000};
        rst(4'hF);
        rreg(8'h08, 16'h0016);
        t_freeze();
        rreg(8'h00, 16'h000F);
        t_cycles();
        t_region();
        t_hold();
        t_straps();
        end_of_test();
    end
    initial begin
        #40000;
        fail_count++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
